// [core/ufib_uart.sv]
`include "ufib_cfg.svh"

// Functional notes
// - Trigger level raises receive-data interrupt and code
// - Line status outranks receive data in ident
// - Data ready set on push, cleared when empty
// - Timeout after four idle character times, FIFO nonempty
// - Character times counted on receive baud ticks
// - Pending timeout cleared by one character read
// - Timer restarts on receive or host read
// - Transmit empty interrupt; cleared by write or ident read
// - Empty indication delayed unless two bytes seen
// - FIFO enable change raises transmit interrupt immediately
// - Timeout shares receive priority; empty shares transmit
// - Polled mode per direction by enable bits
// - Error bits in line status as usual
// - Line status bits 5, 6, 7 in polled
// - Polled mode shows no trigger or timeout
// - Divide reference by divisor for 16x clock
// - High-speed divisors select the fast reference while hs_sel is high
// - Zero divides by three; duty per divisor
module ufib_uart
	import ufib_pkg::*;
#(
	parameter int DEPTH = 16
)(
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	input  wire logic        ref_tick,
	input  wire logic        fast_ref_tick,
	input  wire logic        hs_sel,
	output logic             baud_out,
	output logic             baud_tick,
	input  wire logic        rx_valid,
	input  wire logic [7:0]  rx_data,
	input  wire logic        rx_perr,
	input  wire logic        rx_ferr,
	input  wire logic        rx_brk,
	output logic             tx_valid,
	output logic [7:0]       tx_data,
	input  wire logic        tx_ready,
	input  wire logic        tx_shift_empty,
	output logic             irq
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = AW + 1;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		return a == off;
	endfunction

	logic           pend_reg;
	logic           pwr_reg;
	logic [7:0]     paddr_reg;
	logic [31:0]    hrdata_reg;
	logic [2:0]     ier_reg;
	logic           fifo_en_reg;
	logic [1:0]     trig_reg;
	logic [7:0]     lcr_reg;
	logic [7:0]     scr_reg;
	logic [15:0]    div_reg;
	logic [3:0]     istat_reg;
	logic [3:0]     ien_reg;
	ufib_rx_entry_t rx_mem [DEPTH];
	logic [AW-1:0]  rx_rd_reg;
	logic [AW-1:0]  rx_wr_reg;
	logic [CW-1:0]  rx_cnt_reg;
	ufib_byte_t     tx_mem [DEPTH];
	logic [AW-1:0]  tx_rd_reg;
	logic [AW-1:0]  tx_wr_reg;
	logic [CW-1:0]  tx_cnt_reg;
	logic           oe_reg;
	logic           pe_reg;
	logic           fe_reg;
	logic           bi_reg;
	logic           transmit_holding_empty_reg;
	logic           had_two_reg;
	logic [7:0]     dly_reg;
	logic           thi_reg;
	logic [10:0]    to_cnt_reg;
	logic           to_pend_reg;
	logic           rda_d_reg;
	logic           ls_d_reg;
	logic           hs_reg;
	logic [15:0]    brg_cnt_reg;
	logic           baud_out_reg;

	// Bus access decode; every transfer takes one wait state
	logic wr, rd, wr_thr, rd_rbr, wr_fcr, rd_iir, rd_lsr, fcr_chg;
	assign wr      = pend_reg && pwr_reg;
	assign rd      = pend_reg && !pwr_reg;
	assign wr_thr  = wr && hit(paddr_reg, `UFIB_OFF_DATA);
	assign rd_rbr  = rd && hit(paddr_reg, `UFIB_OFF_DATA);
	assign wr_fcr  = wr && hit(paddr_reg, `UFIB_OFF_IIR_FCR);
	assign rd_iir  = rd && hit(paddr_reg, `UFIB_OFF_IIR_FCR);
	assign rd_lsr  = rd && hit(paddr_reg, `UFIB_OFF_LSR);
	assign fcr_chg = wr_fcr && (hwdata[`UFIB_FCR_EN] != fifo_en_reg);
	assign hreadyout = !pend_reg;
	assign hresp     = 1'b0;
	assign hrdata    = hrdata_reg;

	// Address phase capture; hsize ignored since only whole words are mapped
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			pend_reg  <= 1'b0;
			pwr_reg   <= 1'b0;
			paddr_reg <= 8'h00;
		end
		else
		begin
			pend_reg <= hsel && htrans[1] && hready;
			if (hsel && htrans[1] && hready)
			begin
				paddr_reg <= haddr[7:0];
				pwr_reg   <= hwrite;
			end
		end
	end

	// Character length in bits and in 16x ticks, second stop bit included
	logic [3:0]  char_bits;
	logic [7:0]  char_ticks;
	logic [10:0] to_limit;
	logic [7:0]  dly_limit;
	assign char_bits  = `UFIB_BASE_BITS + {2'h0, lcr_reg[1:0]} + {3'h0, lcr_reg[3]}
		+ {3'h0, lcr_reg[2]};
	assign char_ticks = {char_bits, 4'h0};
	assign to_limit   = 11'(char_ticks) * `UFIB_TO_CHARS;
	assign dly_limit  = char_ticks - `UFIB_STOP_TICKS;

	// Receive FIFO; with FIFOs off it behaves as a single holding register
	logic [CW-1:0] cap, trig_lvl;
	logic rx_full, rx_push, rx_pop, rx_flush, tx_flush;
	ufib_rx_entry_t rx_top, next_top;
	assign cap      = fifo_en_reg ? CW'(DEPTH) : CW'(1);
	assign rx_full  = rx_cnt_reg >= cap;
	assign rx_push  = rx_valid && !rx_full;
	assign rx_pop   = rd_rbr && rx_cnt_reg != '0;
	assign rx_flush = fcr_chg || (wr_fcr && hwdata[`UFIB_FCR_RXRST]);
	assign tx_flush = fcr_chg || (wr_fcr && hwdata[`UFIB_FCR_TXRST]);
	assign rx_top   = rx_mem[rx_rd_reg];
	assign next_top = (rx_cnt_reg == '0) ? ufib_rx_entry_t'({rx_brk, rx_ferr, rx_perr, rx_data})
		: rx_mem[rx_rd_reg + AW'(1)];
	assign trig_lvl = (trig_reg == 2'h0) ? CW'(1) : (trig_reg == 2'h1) ? CW'(4)
		: (trig_reg == 2'h2) ? CW'(8) : CW'(14);

	always_ff @(posedge hclk)
	begin
		if (rx_push)
			rx_mem[rx_wr_reg] <= {rx_brk, rx_ferr, rx_perr, rx_data};
		if (wr_thr && tx_cnt_reg < cap)
			tx_mem[tx_wr_reg] <= hwdata[7:0];
	end

	// Receive pointers and fill
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			rx_rd_reg  <= '0;
			rx_wr_reg  <= '0;
			rx_cnt_reg <= '0;
		end
		else if (rx_flush)
		begin
			rx_rd_reg  <= '0;
			rx_wr_reg  <= '0;
			rx_cnt_reg <= '0;
		end
		else
		begin
			if (rx_push)
				rx_wr_reg <= rx_wr_reg + AW'(1);
			if (rx_pop)
				rx_rd_reg <= rx_rd_reg + AW'(1);
			rx_cnt_reg <= rx_cnt_reg + CW'(rx_push) - CW'(rx_pop);
		end
	end

	// Any error among the held characters, for line status bit 7
	logic fifo_err;
	always_comb
	begin
		fifo_err = 1'b0;
		for (int i = 0; i < DEPTH; i++)
		begin
			if ({1'b0, AW'(i) - rx_rd_reg} < rx_cnt_reg
				&& (rx_mem[i].brk || rx_mem[i].ferr || rx_mem[i].perr))
				fifo_err = 1'b1;
		end
	end

	// Sticky error flags; a new error wins over the clearing read
	logic new_top;
	assign new_top = (rx_push && rx_cnt_reg == '0) || (rx_pop && rx_cnt_reg > CW'(1));
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			oe_reg <= 1'b0;
			pe_reg <= 1'b0;
			fe_reg <= 1'b0;
			bi_reg <= 1'b0;
		end
		else
		begin
			oe_reg <= (rx_valid && rx_full) || (oe_reg && !rd_lsr);
			pe_reg <= (new_top && next_top.perr) || (pe_reg && !rd_lsr);
			fe_reg <= (new_top && next_top.ferr) || (fe_reg && !rd_lsr);
			bi_reg <= (new_top && next_top.brk) || (bi_reg && !rd_lsr);
		end
	end

	// Transmit FIFO; the shifter drains it through tx_valid and tx_ready
	logic tx_push, tx_pop, tx_empty, transmit_holding_empty_set;
	assign tx_push  = wr_thr && tx_cnt_reg < cap;
	assign tx_pop   = tx_valid && tx_ready;
	assign tx_empty = tx_cnt_reg == '0;
	assign tx_valid = !tx_empty;
	assign tx_data  = tx_mem[tx_rd_reg];

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			tx_rd_reg  <= '0;
			tx_wr_reg  <= '0;
			tx_cnt_reg <= '0;
		end
		else if (tx_flush)
		begin
			tx_rd_reg  <= '0;
			tx_wr_reg  <= '0;
			tx_cnt_reg <= '0;
		end
		else
		begin
			if (tx_push)
				tx_wr_reg <= tx_wr_reg + AW'(1);
			if (tx_pop)
				tx_rd_reg <= tx_rd_reg + AW'(1);
			tx_cnt_reg <= tx_cnt_reg + CW'(tx_push) - CW'(tx_pop);
		end
	end

	// Empty indication; a lone byte holds it back by one character less a stop bit
	// A FIFO enable change fires even when the indication already stands
	assign transmit_holding_empty_set = fcr_chg || (!transmit_holding_empty_reg && tx_empty && !tx_push
		&& (had_two_reg || dly_reg >= dly_limit));
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			transmit_holding_empty_reg    <= 1'b1;
			had_two_reg <= 1'b0;
			dly_reg     <= 8'h00;
		end
		else
		begin
			if (tx_push)
				transmit_holding_empty_reg <= 1'b0;
			else if (transmit_holding_empty_set)
				transmit_holding_empty_reg <= 1'b1;
			if (transmit_holding_empty_set)
				had_two_reg <= 1'b0;
			else if (tx_cnt_reg >= CW'(2))
				had_two_reg <= 1'b1;
			if (!tx_empty || transmit_holding_empty_reg)
				dly_reg <= 8'h00;
			else if (baud_tick && dly_reg != 8'hFF)
				dly_reg <= dly_reg + 8'h01;
		end
	end

	// Interrupt conditions and identification, highest priority first
	logic rda_cond, ls_cond, to_set, transmit_holding_empty_cond;
	logic [3:0] iir_id;
	assign ls_cond   = ier_reg[`UFIB_IER_RLS] && (oe_reg || pe_reg || fe_reg || bi_reg);
	assign rda_cond  = ier_reg[`UFIB_IER_RDA]
		&& (fifo_en_reg ? rx_cnt_reg >= trig_lvl : rx_cnt_reg != '0);
	assign transmit_holding_empty_cond = ier_reg[`UFIB_IER_TRANSMIT_HOLDING_EMPTY] && thi_reg;
	always_comb
	begin
		if (ls_cond)
			iir_id = `UFIB_IIR_RLS;
		else if (to_pend_reg && ier_reg[`UFIB_IER_RDA])
			iir_id = `UFIB_IIR_TO;
		else if (rda_cond)
			iir_id = `UFIB_IIR_RDA;
		else if (transmit_holding_empty_cond)
			iir_id = `UFIB_IIR_TRANSMIT_HOLDING_EMPTY;
		else
			iir_id = `UFIB_IIR_NONE;
	end

	// Receive timeout timer on 16x baud ticks; reads and arrivals restart it
	assign to_set = !to_pend_reg && rx_cnt_reg != '0 && to_cnt_reg > to_limit
		&& fifo_en_reg && ier_reg[`UFIB_IER_RDA] && !rx_push && !rx_pop;
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			to_cnt_reg  <= 11'h000;
			to_pend_reg <= 1'b0;
		end
		else
		begin
			if (rx_push || rx_pop || rx_cnt_reg == '0)
				to_cnt_reg <= 11'h000;
			else if (baud_tick && to_cnt_reg != 11'h7FF)
				to_cnt_reg <= to_cnt_reg + 11'h001;
			if (to_set)
				to_pend_reg <= 1'b1;
			else if (rx_pop || rx_flush || !ier_reg[`UFIB_IER_RDA])
				to_pend_reg <= 1'b0;
		end
	end

	// Transmit interrupt: set on empty or enable change, cleared by data write or ident read
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			thi_reg <= 1'b0;
		else if (transmit_holding_empty_set || (wr && hit(paddr_reg, `UFIB_OFF_IER)
			&& hwdata[`UFIB_IER_TRANSMIT_HOLDING_EMPTY] && !ier_reg[`UFIB_IER_TRANSMIT_HOLDING_EMPTY] && transmit_holding_empty_reg))
			thi_reg <= 1'b1;
		else if (wr_thr || (rd_iir && iir_id == `UFIB_IIR_TRANSMIT_HOLDING_EMPTY))
			thi_reg <= 1'b0;
	end

	// Control registers written by software
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			ier_reg     <= 3'h0;
			fifo_en_reg <= 1'b0;
			trig_reg    <= 2'h0;
			lcr_reg     <= 8'h00;
			scr_reg     <= 8'h00;
			div_reg     <= `UFIB_DIV_RST;
			ien_reg     <= 4'h0;
		end
		else if (wr)
		begin
			if (hit(paddr_reg, `UFIB_OFF_IER))
				ier_reg <= hwdata[2:0];
			if (wr_fcr)
			begin
				fifo_en_reg <= hwdata[`UFIB_FCR_EN];
				trig_reg    <= hwdata[7:6];
			end
			if (hit(paddr_reg, `UFIB_OFF_LCR))
				lcr_reg <= hwdata[7:0];
			if (hit(paddr_reg, `UFIB_OFF_SCR))
				scr_reg <= hwdata[7:0];
			if (hit(paddr_reg, `UFIB_OFF_DIV))
				div_reg <= hwdata[15:0];
			if (hit(paddr_reg, `UFIB_OFF_IEN))
				ien_reg <= hwdata[3:0];
		end
	end

	// Sticky event bits; an event in the clearing cycle survives
	logic [3:0] ev;
	assign ev = {ls_cond && !ls_d_reg, transmit_holding_empty_set, to_set, rda_cond && !rda_d_reg};
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			istat_reg <= 4'h0;
			rda_d_reg <= 1'b0;
			ls_d_reg  <= 1'b0;
		end
		else
		begin
			rda_d_reg <= rda_cond;
			ls_d_reg  <= ls_cond;
			if (wr && hit(paddr_reg, `UFIB_OFF_ICLR))
				istat_reg <= (istat_reg & ~hwdata[3:0]) | ev;
			else
				istat_reg <= istat_reg | ev;
		end
	end
	assign irq = |(istat_reg & ien_reg);

	// Line status image and read data capture
	logic [7:0]  lsr_val;
	logic [31:0] rd_val;
	assign lsr_val = {fifo_en_reg && fifo_err, transmit_holding_empty_reg && tx_shift_empty, transmit_holding_empty_reg,
		bi_reg, fe_reg, pe_reg, oe_reg, rx_cnt_reg != '0};
	always_comb
	begin
		rd_val = 32'h0000_0000;
		case (paddr_reg)
			`UFIB_OFF_DATA:    rd_val = {24'h00_0000, rx_top.data};
			`UFIB_OFF_IER:     rd_val = {29'h0000_0000, ier_reg};
			`UFIB_OFF_IIR_FCR: rd_val = {24'h00_0000, {2{fifo_en_reg}}, 2'h0, iir_id};
			`UFIB_OFF_LCR:     rd_val = {24'h00_0000, lcr_reg};
			`UFIB_OFF_LSR:     rd_val = {24'h00_0000, lsr_val};
			`UFIB_OFF_SCR:     rd_val = {24'h00_0000, scr_reg};
			`UFIB_OFF_DIV:     rd_val = {16'h0000, div_reg};
			`UFIB_OFF_ISTAT:   rd_val = {28'h000_0000, istat_reg};
			`UFIB_OFF_IEN:     rd_val = {28'h000_0000, ien_reg};
			default:           rd_val = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			hrdata_reg <= 32'h0000_0000;
		else if (rd)
			hrdata_reg <= rd_val;
	end

	// Baud divider; the high-speed select and divisor bit 15 together pick the fast reference
	logic        use_fast, src_tick;
	logic [15:0] div_n;
	assign use_fast = hs_reg && div_reg[`UFIB_DIV_HS];
	assign src_tick = use_fast ? fast_ref_tick : ref_tick;
	assign div_n    = use_fast ? {1'b0, div_reg[14:0]} : div_reg;
	logic [15:0] div_eff;
	assign div_eff   = (div_n == 16'h0000) ? `UFIB_DIV_ZERO : div_n;
	assign baud_tick = src_tick && brg_cnt_reg == div_eff - 16'h0001;
	assign baud_out  = baud_out_reg;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			hs_reg       <= 1'b0;
			brg_cnt_reg  <= 16'h0000;
			baud_out_reg <= 1'b0;
		end
		else
		begin
			hs_reg <= hs_sel;
			if (wr && hit(paddr_reg, `UFIB_OFF_DIV))
				brg_cnt_reg <= 16'h0000; // Reload avoids a long first count
			else if (baud_tick)
				brg_cnt_reg <= 16'h0000;
			else if (src_tick)
				brg_cnt_reg <= brg_cnt_reg + 16'h0001;
			if (src_tick)
			begin
				if (div_eff == 16'h0001)
					baud_out_reg <= !baud_out_reg;
				else
					baud_out_reg <= !baud_tick && brg_cnt_reg != 16'h0000;
			end
		end
	end

	a_rda_level: assert property (@(posedge hclk) disable iff (!hresetn)
		(fifo_en_reg && ier_reg[0] && rx_cnt_reg >= trig_lvl && !ls_cond && !to_pend_reg)
		|-> iir_id == `UFIB_IIR_RDA) else $error("trigger level not reported");
	a_ls_priority: assert property (@(posedge hclk) disable iff (!hresetn)
		ls_cond |-> iir_id == `UFIB_IIR_RLS) else $error("line status not first");
	a_dr_on_push: assert property (@(posedge hclk) disable iff (!hresetn)
		(rx_push && !rx_flush) |=> lsr_val[0]) else $error("data ready missed");
	a_to_after_idle: assert property (@(posedge hclk) disable iff (!hresetn)
		$rose(to_pend_reg) |-> $past(to_cnt_reg) > $past(to_limit) && rx_cnt_reg != '0)
		else $error("timeout too early");
	a_to_read_clear: assert property (@(posedge hclk) disable iff (!hresetn)
		(to_pend_reg && rx_pop) |=> !to_pend_reg && to_cnt_reg == 11'h000)
		else $error("timeout not cleared by read");
	a_to_restart: assert property (@(posedge hclk) disable iff (!hresetn)
		rx_push |=> to_cnt_reg == 11'h000) else $error("timer not restarted");
	a_transmit_holding_empty_write_clear: assert property (@(posedge hclk) disable iff (!hresetn)
		(wr_thr && !transmit_holding_empty_set) |=> !thi_reg ##1 !transmit_holding_empty_reg || thi_reg)
		else $error("transmit interrupt not cleared");
	a_fcr_immediate: assert property (@(posedge hclk) disable iff (!hresetn)
		(fcr_chg && ier_reg[1]) |=> transmit_holding_empty_reg && thi_reg && iir_id != `UFIB_IIR_NONE)
		else $error("enable change not immediate");
	a_polled_quiet: assert property (@(posedge hclk) disable iff (!hresetn)
		!ier_reg[0] |-> iir_id != `UFIB_IIR_RDA && iir_id != `UFIB_IIR_TO)
		else $error("polled mode shows receive interrupt");

endmodule // ufib_uart

// [core/ufib_cfg.svh]
`ifndef UFIB_CFG_SVH
`define UFIB_CFG_SVH

// Register byte offsets (one 32-bit word each)
`define UFIB_OFF_DATA     8'h00
`define UFIB_OFF_IER      8'h04
`define UFIB_OFF_IIR_FCR  8'h08
`define UFIB_OFF_LCR      8'h0C
`define UFIB_OFF_LSR      8'h14
`define UFIB_OFF_SCR      8'h1C
`define UFIB_OFF_DIV      8'h20
`define UFIB_OFF_ISTAT    8'h24
`define UFIB_OFF_IEN      8'h28
`define UFIB_OFF_ICLR     8'h2C

// Field positions
`define UFIB_IER_RDA      0
`define UFIB_IER_TRANSMIT_HOLDING_EMPTY     1
`define UFIB_IER_RLS      2
`define UFIB_FCR_EN       0
`define UFIB_FCR_RXRST    1
`define UFIB_FCR_TXRST    2
`define UFIB_DIV_HS       15

// Identification codes
`define UFIB_IIR_NONE     4'h1
`define UFIB_IIR_RLS      4'h6
`define UFIB_IIR_RDA      4'h4
`define UFIB_IIR_TO       4'hC
`define UFIB_IIR_TRANSMIT_HOLDING_EMPTY     4'h2

// Reset values
`define UFIB_LSR_RST      8'h60
`define UFIB_DIV_RST      16'h000C

// Timing counts
`define UFIB_TO_CHARS     11'h004
`define UFIB_BASE_BITS    4'h7
`define UFIB_STOP_TICKS   8'h10
`define UFIB_DIV_ZERO     16'h0003

`endif

// [core/ufib_pkg.sv]
package ufib_pkg;

	// One received character with its error flags
	typedef struct packed
	{
		logic       brk;
		logic       ferr;
		logic       perr;
		logic [7:0] data;
	} ufib_rx_entry_t;

	typedef logic [7:0] ufib_byte_t;

endpackage

// [tb/ufib_far_end.sv]
// Remote serial device seen through its shifters: feeds received characters and
// drains the transmit side, with a stall input to hold the transmitter back.
module ufib_far_end
	import ufib_pkg::*;
#(
	parameter int SHIFT_CYC = 40
)(
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       stall,
	input  wire logic       tx_valid,
	input  wire logic [7:0] tx_data,
	output logic            rx_valid,
	output logic [7:0]      rx_data,
	output logic            rx_perr,
	output logic            rx_ferr,
	output logic            rx_brk,
	output logic            tx_ready,
	output logic            tx_shift_empty
);
	timeunit 1ns;
	timeprecision 1ps;

	ufib_byte_t got_q[$];
	int         busy;

	// Shifter takes one byte, then stays busy for SHIFT_CYC bus cycles
	assign tx_ready       = !stall && busy == 0;
	assign tx_shift_empty = busy == 0;

	// Record every byte that leaves the block
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			busy <= 0;
		else if (tx_valid && tx_ready)
		begin
			got_q.push_back(tx_data);
			busy <= SHIFT_CYC;
		end
		else if (busy > 0)
			busy <= busy - 1;
	end

	// Idle receive lines
	initial
	begin
		rx_valid = 1'b0;
		rx_data = 8'h00;
		{rx_brk, rx_ferr, rx_perr} = 3'h0;
	end

	// One character; lines show the inverse afterwards so stale data never passes for valid
	task automatic send(input ufib_byte_t d, input logic [2:0] fl);
		rx_valid <= 1'b1;
		rx_data <= d;
		{rx_brk, rx_ferr, rx_perr} <= fl;
		@(posedge clk);
		rx_valid <= 1'b0;
		rx_data <= ~d;
		{rx_brk, rx_ferr, rx_perr} <= ~fl;
	endtask
endmodule // ufib_far_end

// [tb/tb_uart_fifo_interrupt_baud.sv]
`include "ufib_cfg.svh"

module tb_uart_fifo_interrupt_baud
	import ufib_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	localparam logic [7:0] o_dat = `UFIB_OFF_DATA;
	localparam logic [7:0] o_ier = `UFIB_OFF_IER;
	localparam logic [7:0] o_iir = `UFIB_OFF_IIR_FCR;
	localparam logic [7:0] o_lsr = `UFIB_OFF_LSR;
	localparam logic [7:0] o_div = `UFIB_OFF_DIV;
	localparam logic [7:0] o_ist = `UFIB_OFF_ISTAT;
	localparam logic [7:0] o_ien = `UFIB_OFF_IEN;

	logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, hs_sel, stall;
	logic        baud_out, baud_tick, rx_valid, rx_perr, rx_ferr, rx_brk, irq;
	logic        tx_valid, tx_ready, tx_shift_empty;
	logic        ref_tick = 1'b0;
	logic        fast_ref_tick = 1'b0;
	logic [2:0]  ph = 3'h0;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [31:0] haddr, hwdata, hrdata, rdat;
	logic [7:0]  rx_data, tx_data;
	logic [15:0] divs[7] = '{16'h0000, 16'h0001, 16'h0002, 16'h0003, 16'h8002, 16'h8001, 16'h8002};
	logic        hsv[7] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
	ufib_byte_t  rx_q[$], tx_q[$];
	int          err_count, n_compared, c, e;

	assign hready = hreadyout;

	ufib_uart dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .ref_tick(ref_tick),
		.fast_ref_tick(fast_ref_tick), .hs_sel(hs_sel), .baud_out(baud_out),
		.baud_tick(baud_tick), .rx_valid(rx_valid), .rx_data(rx_data), .rx_perr(rx_perr),
		.rx_ferr(rx_ferr), .rx_brk(rx_brk), .tx_valid(tx_valid), .tx_data(tx_data),
		.tx_ready(tx_ready), .tx_shift_empty(tx_shift_empty), .irq(irq));

	ufib_far_end far_u (.clk(hclk), .rst_n(hresetn), .stall(stall), .tx_valid(tx_valid),
		.tx_data(tx_data), .rx_valid(rx_valid), .rx_data(rx_data), .rx_perr(rx_perr),
		.rx_ferr(rx_ferr), .rx_brk(rx_brk), .tx_ready(tx_ready),
		.tx_shift_empty(tx_shift_empty));

	// 100 MHz bus clock
	initial
	begin
		hclk = 1'b0;
		forever #5 hclk = ~hclk;
	end

	// Reference tick every eight cycles; fast reference four times as often
	always @(posedge hclk)
	begin
		ph <= ph + 3'h1;
		ref_tick <= (ph == 3'h7);
		fast_ref_tick <= ph[0];
	end

	task automatic print_verdict();
		$display("Comparisons %0d, mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic fail(input string m);
		err_count++;
		$display("[ERR] %0t %s", $time, m);
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		n_compared++;
		if (got !== exp)
			fail($sformatf("%s got %h exp %h", m, got, exp));
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge hclk);
	endtask

	// Ready seen at the falling edge is what the master samples at the next rising edge
	task automatic wait_rdy(output logic [31:0] d);
		int  n;
		logic r;
		n = 0;
		r = 1'b0;
		while (r !== 1'b1 && n < 50)
		begin
			@(negedge hclk);
			r = hreadyout;
			d = hrdata;
			@(posedge hclk);
			n++;
		end
		if (r !== 1'b1)
		begin
			fail("bus hang");
			print_verdict();
		end
	endtask

	// One single word transfer: address phase, then data phase
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
		logic [31:0] d;
		hsel <= 1'b1;
		haddr <= {24'h00_0000, a};
		htrans <= 2'h2;
		hwrite <= w;
		wait_rdy(d);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		wait_rdy(rdat);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] mk, input logic [7:0] x, input string m);
		bus(1'b0, a, 32'h0000_0000);
		chk(rdat & {24'h00_0000, mk}, {24'h00_0000, x}, m);
	endtask

	// Repeat a read until the field matches or the bound runs out
	task automatic poll(input logic [7:0] a, input logic [7:0] mk, input logic [7:0] x, input string m);
		int i;
		i = 0;
		do
		begin
			bus(1'b0, a, 32'h0000_0000);
			i++;
		end
		while ((rdat[7:0] & mk) !== x && i < 600);
		chk(rdat & {24'h00_0000, mk}, {24'h00_0000, x}, m);
	endtask

	task automatic send(input logic [2:0] fl);
		ufib_byte_t d;
		d = ufib_byte_t'($urandom);
		rx_q.push_back(d);
		far_u.send(d, fl);
		cyc(2);
	endtask

	task automatic pop_chk();
		bus(1'b0, o_dat, 32'h0000_0000);
		chk({24'h00_0000, rdat[7:0]}, {24'h00_0000, rx_q.pop_front()}, "rx data");
	endtask

	task automatic send_tx();
		ufib_byte_t d;
		d = ufib_byte_t'($urandom);
		tx_q.push_back(d);
		wr(o_dat, {24'h00_0000, d});
	endtask

	task automatic wait_txidle();
		int n;
		n = 0;
		while (tx_valid !== 1'b0 && n < 500)
		begin
			@(posedge hclk);
			n++;
		end
		if (n >= 500)
			fail("tx stuck");
	endtask

	task automatic chk_irq(input logic x);
		@(negedge hclk);
		chk({31'h0000_0000, irq}, {31'h0000_0000, x}, "irq line");
		@(posedge hclk);
	endtask

	task automatic count_ticks(input int n, output int k);
		k = 0;
		repeat (n)
		begin
			@(negedge hclk);
			k += (baud_tick === 1'b1) ? 1 : 0;
		end
		@(posedge hclk);
	endtask

	// Baud ticks expected over n bus cycles with the reference rates above
	function automatic int exp_ticks(input logic [15:0] dv, input logic hs, input int n);
		if (hs && dv[15])
			return (n / 2) / ((dv[14:0] == 15'h0000) ? 3 : int'(dv[14:0]));
		return (n / 8) / ((dv == 16'h0000) ? 3 : int'(dv));
	endfunction

	// Main sequence
	initial
	begin
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0000_0000;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0000_0000;
		hs_sel = 1'b0;
		stall = 1'b0;
		err_count = 0;
		n_compared = 0;
		void'($urandom(98));
		cyc(10);
		hresetn <= 1'b1;
		rd(o_lsr, 8'hFF, 8'h60, "lsr reset");
		rd(o_iir, 8'hFF, 8'h01, "iir reset");
		bus(1'b0, o_div, 32'h0000_0000);
		chk(rdat, 32'h0000_000C, "divisor reset");
		rd(8'h30, 8'hFF, 8'h00, "unmapped");
		for (int i = 0; i < 7; i++)
		begin
			hs_sel <= hsv[i];
			wr(o_div, {16'h0000, divs[i]});
			cyc(20);
			count_ticks(480, c);
			e = exp_ticks(divs[i], hsv[i], 480);
			chk({31'h0000_0000, c >= e - 1 && c <= e + 1}, 32'h0000_0001, "baud rate");
		end
		hs_sel <= 1'b0;
		wr(o_div, 32'h0000_0001);
		wr(o_ier, 32'h0000_0002);
		wr(o_iir, 32'h0000_0047);
		wr(`UFIB_OFF_LCR, 32'h0000_0003);
		rd(o_iir, 8'hFF, 8'hC2, "tx irq on enable");
		rd(o_iir, 8'hFF, 8'hC1, "ident read clears");
		rd(o_ist, 8'h04, 8'h04, "tx status");
		wr(o_ien, 32'h0000_0004);
		chk_irq(1'b1);
		wr(o_ien, 32'h0000_0000);
		chk_irq(1'b0);
		wr(o_ien, 32'h0000_0004);
		wr(`UFIB_OFF_ICLR, 32'h0000_0004);
		rd(o_ist, 8'h04, 8'h00, "status cleared");
		chk_irq(1'b0);
		// Receive trigger level and timeout
		wr(o_ier, 32'h0000_0005);
		repeat (3) send(3'h0);
		rd(o_iir, 8'hFF, 8'hC1, "below trigger");
		rd(o_lsr, 8'h01, 8'h01, "data ready");
		send(3'h0);
		rd(o_iir, 8'hFF, 8'hC4, "trigger reached");
		pop_chk();
		rd(o_iir, 8'hFF, 8'hC1, "below again");
		cyc(4000);
		rd(o_iir, 8'hFF, 8'hC1, "no early timeout");
		poll(o_iir, 8'hFF, 8'hCC, "timeout");
		pop_chk();
		rd(o_iir, 8'hFF, 8'hC1, "timeout cleared");
		cyc(4000);
		rd(o_iir, 8'hFF, 8'hC1, "timer restarted");
		repeat (2) pop_chk();
		rd(o_lsr, 8'h01, 8'h00, "data ready clear");
		// Line status ahead of receive data
		send(3'h1);
		repeat (3) send(3'h0);
		rd(o_iir, 8'hFF, 8'hC6, "line status first");
		rd(o_lsr, 8'h85, 8'h85, "parity error");
		rd(o_iir, 8'hFF, 8'hC4, "data after status");
		// Polled receive
		wr(o_ier, 32'h0000_0000);
		rd(o_iir, 8'hFF, 8'hC1, "polled no trigger");
		cyc(6000);
		rd(o_iir, 8'hFF, 8'hC1, "polled no timeout");
		repeat (4) pop_chk();
		send(3'h2);
		rd(o_lsr, 8'h8F, 8'h89, "polled framing");
		rd(o_iir, 8'hFF, 8'hC1, "ident untouched");
		pop_chk();
		// Transmit empty, its delay and its clearing
		wr(o_ier, 32'h0000_0002);
		bus(1'b0, o_iir, 32'h0000_0000);
		stall <= 1'b1;
		send_tx();
		rd(o_lsr, 8'h60, 8'h00, "tx holding");
		stall <= 1'b0;
		cyc(600);
		rd(o_lsr, 8'h20, 8'h00, "empty delayed");
		poll(o_lsr, 8'h60, 8'h60, "tx empty");
		rd(o_iir, 8'hFF, 8'hC2, "tx irq");
		rd(o_iir, 8'hFF, 8'hC1, "ident clears");
		stall <= 1'b1;
		repeat (2) send_tx();
		stall <= 1'b0;
		wait_txidle();
		rd(o_lsr, 8'h20, 8'h20, "no delay after two");
		rd(o_iir, 8'hFF, 8'hC2, "tx irq again");
		send_tx();
		rd(o_iir, 8'hFF, 8'hC1, "write clears");
		wait_txidle();
		chk(32'(far_u.got_q.size()), 32'(tx_q.size()), "tx count");
		foreach (tx_q[i])
			chk({24'h00_0000, far_u.got_q[i]}, {24'h00_0000, tx_q[i]}, "tx data");
		print_verdict();
	end
endmodule // tb_uart_fifo_interrupt_baud
